// ---- logic/fdp_divider_regs.sv ----
`timescale 1ns/100ps
module fdp_divider_regs
	import fdp_pkg::*;
#(
	parameter int WORD_BITS = WORD_W
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic ser_clk,
	input wire logic ser_data,
	input wire logic latch_en,
	input wire logic reference_input,
	input wire logic rf_input,
	input wire logic [3:0] cp_setting,
	input wire logic lock_window_select,
	input wire logic ref_phase,
	input wire logic fb_phase,
	output logic [3:0] cp_current,
	output logic test_out_o,
	output logic test_out_oe,
	output logic lock_detect,
	output logic phase_comparator_ref,
	output logic phase_comparator_fb,
	output logic prescaler_select,
	output logic [11:0] resync_delay
);
	// ==========================================================
	// Pin synchronisers and edge detection.
	logic [2:0] sck_s, le_s, dat_s, ref_s, rf_s, rp_s, fp_s;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			sck_s <= 3'h0;
			le_s <= 3'h0;
			dat_s <= 3'h0;
			ref_s <= 3'h0;
			rf_s <= 3'h0;
			rp_s <= 3'h0;
			fp_s <= 3'h0;
		end
		else
		begin
			sck_s <= {sck_s[1:0], ser_clk};
			le_s <= {le_s[1:0], latch_en};
			dat_s <= {dat_s[1:0], ser_data};
			ref_s <= {ref_s[1:0], reference_input};
			rf_s <= {rf_s[1:0], rf_input};
			rp_s <= {rp_s[1:0], ref_phase};
			fp_s <= {fp_s[1:0], fb_phase};
		end
	end
	logic sck_rise, le_rise, ref_rise, rf_rise, rp_rise, fp_rise;
	assign sck_rise = sck_s[1] & ~sck_s[2];
	assign le_rise = le_s[1] & ~le_s[2];
	assign ref_rise = ref_s[1] & ~ref_s[2];
	assign rf_rise = rf_s[1] & ~rf_s[2];
	assign rp_rise = rp_s[1] & ~rp_s[2];
	assign fp_rise = fp_s[1] & ~fp_s[2];

	// ==========================================================
	// Serial shift register and word latch.
	logic [WORD_BITS-1:0] shift;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			shift <= '0;
		else if (sck_rise)
			shift <= {shift[WORD_BITS-2:0], dat_s[1]};
	end
	logic load_n, load_r;
	assign load_n = le_rise && shift[1:0] == SEL_N_WORD;
	assign load_r = le_rise && shift[1:0] == SEL_R_WORD;

	// ==========================================================
	// Divider registers.
	logic rapid_settle;
	logic [8:0] whole_divide_part;
	logic [11:0] fine_numerator, fine_denominator, den_pending;
	logic [2:0] test_output_select;
	logic [3:0] ref_count;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rapid_settle <= 1'b0;
			whole_divide_part <= WHOLE_RESET;
			fine_numerator <= FINE_RESET;
			fine_denominator <= DEN_RESET;
		end
		else if (load_n)
		begin
			rapid_settle <= shift[N_RAPID_BIT];
			whole_divide_part <= shift[N_WHOLE_MSB:N_WHOLE_LSB];
			fine_numerator <= shift[N_FINE_MSB:N_FINE_LSB];
			fine_denominator <= den_pending;
		end
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			den_pending <= DEN_RESET;
			resync_delay <= 12'h000;
			test_output_select <= MUX_TRISTATE;
			prescaler_select <= 1'b0;
			ref_count <= REFC_RESET;
		end
		else if (load_r)
		begin
			test_output_select <= shift[R_MUX_MSB:R_MUX_LSB];
			prescaler_select <= shift[R_PRESC_BIT];
			ref_count <= shift[R_REFC_MSB:R_REFC_LSB];
			if (shift[R_LOAD_BIT])
				resync_delay <= shift[R_DEN_MSB:R_DEN_LSB];
			else
				den_pending <= shift[R_DEN_MSB:R_DEN_LSB];
		end
	end

	// ==========================================================
	// Charge pump current.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
			cp_current <= 4'h0;
		else
			cp_current <= rapid_settle ? CP_MAX : cp_setting;
	end

	// ==========================================================
	// Reference counter.
	logic [3:0] ref_cnt;
	logic ref_tick;
	assign ref_tick = ref_rise && ref_cnt <= 4'h1;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ref_cnt <= 4'h0;
			phase_comparator_ref <= 1'b0;
		end
		else
		begin
			if (ref_rise)
				ref_cnt <= ref_tick ? ref_count : ref_cnt - 4'h1;
			if (ref_tick)
				phase_comparator_ref <= ~phase_comparator_ref;
		end
	end

	// ==========================================================
	// Feedback divider with fractional accumulator.
	logic [3:0] pre_mod;
	logic [12:0] fb_cnt, fb_target;
	logic [12:0] acc, acc_sum;
	logic ovf, fb_tick;
	assign pre_mod = prescaler_select ? 4'h8 : 4'h4;
	assign acc_sum = acc + {1'b0, fine_numerator};
	assign ovf = acc_sum >= {1'b0, fine_denominator};
	assign fb_target = {4'h0, whole_divide_part} + {12'h000, ovf};
	assign fb_tick = rf_rise && fb_cnt + 13'h1 >= fb_target;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fb_cnt <= 13'h0000;
			acc <= 13'h0000;
			phase_comparator_fb <= 1'b0;
		end
		else if (load_n)
		begin
			fb_cnt <= 13'h0000;
			acc <= 13'h0000;
		end
		else if (rf_rise)
		begin
			// Prescaler modulus pre_mod is unused; the count is the whole part plus overflow only.
			if (fb_tick)
			begin
				fb_cnt <= 13'h0000;
				phase_comparator_fb <= ~phase_comparator_fb;
				acc <= ovf ? acc_sum - {1'b0, fine_denominator}
					: acc_sum;
			end
			else
				fb_cnt <= fb_cnt + 13'h1;
		end
	end

	// ==========================================================
	// Digital lock detect.
	logic [5:0] good_cnt, err_cnt;
	logic in_err;
	logic [5:0] lock_need;
	logic cmp_done, cmp_small, err_large;
	assign lock_need = lock_window_select ? 6'(LOCK_CNT_WIDE)
		: 6'(LOCK_CNT_NARROW);
	// A comparison ends when both edges coincide or the late edge arrives.
	assign cmp_done = (!in_err && rp_rise && fp_rise)
		|| (in_err && (rp_rise || fp_rise));
	// Only an error shorter than the set limit extends the good run.
	assign cmp_small = !in_err || err_cnt < 6'(SET_ERR_CYC);
	// An error beyond the clear limit drops lock even before it ends.
	assign err_large = in_err && err_cnt > 6'(CLEAR_ERR_CYC);
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			in_err <= 1'b0;
			err_cnt <= 6'h00;
		end
		else if (rp_rise != fp_rise && !in_err)
		begin
			in_err <= 1'b1;
			err_cnt <= 6'h01;
		end
		else if (in_err && (rp_rise || fp_rise))
			in_err <= 1'b0;
		else if (in_err && err_cnt != 6'h3F)
			err_cnt <= err_cnt + 6'h01;
	end
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			good_cnt <= 6'h00;
			lock_detect <= 1'b0;
		end
		else if (load_n || err_large)
		begin
			good_cnt <= 6'h00;
			lock_detect <= 1'b0;
		end
		else if (cmp_done && !cmp_small)
			good_cnt <= 6'h00;
		else if (cmp_done)
		begin
			if (good_cnt + 6'h01 >= lock_need)
				lock_detect <= 1'b1;
			else
				good_cnt <= good_cnt + 6'h01;
		end
	end

	// ==========================================================
	// Test output multiplexer.
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			test_out_o <= 1'b0;
			test_out_oe <= 1'b0;
		end
		else
		begin
			test_out_oe <= 1'b1;
			case (test_output_select)
				MUX_TRISTATE: test_out_oe <= 1'b0;
				MUX_LOCK: test_out_o <= lock_detect;
				MUX_NDIV: test_out_o <= phase_comparator_fb;
				MUX_HIGH: test_out_o <= 1'b1;
				MUX_RDIV: test_out_o <= phase_comparator_ref;
				MUX_RAPID:
				begin
					test_out_o <= 1'b0;
					test_out_oe <= rapid_settle;
				end
				MUX_LOW: test_out_o <= 1'b0;
				default: test_out_oe <= 1'b0;
			endcase
		end
	end
	logic unused;
	assign unused = pre_mod[0];
endmodule : fdp_divider_regs

// ---- logic/fdp_pkg.sv ----
package fdp_pkg;
	localparam int WORD_W = 24;
	localparam logic [1:0] SEL_N_WORD = 2'h0;
	localparam logic [1:0] SEL_R_WORD = 2'h1;
	localparam int N_RAPID_BIT = 23;
	localparam int N_WHOLE_MSB = 22;
	localparam int N_WHOLE_LSB = 14;
	localparam int N_FINE_MSB = 13;
	localparam int N_FINE_LSB = 2;
	localparam int R_LOAD_BIT = 23;
	localparam int R_MUX_MSB = 22;
	localparam int R_MUX_LSB = 20;
	localparam int R_PRESC_BIT = 18;
	localparam int R_REFC_MSB = 17;
	localparam int R_REFC_LSB = 14;
	localparam int R_DEN_MSB = 13;
	localparam int R_DEN_LSB = 2;
	localparam logic [8:0] WHOLE_RESET = 9'h000;
	localparam logic [11:0] FINE_RESET = 12'h000;
	localparam logic [11:0] DEN_RESET = 12'h002;
	localparam logic [3:0] REFC_RESET = 4'h1;
	localparam logic [3:0] CP_MAX = 4'hF;
	localparam logic [2:0] MUX_TRISTATE = 3'h0;
	localparam logic [2:0] MUX_LOCK = 3'h1;
	localparam logic [2:0] MUX_NDIV = 3'h2;
	localparam logic [2:0] MUX_HIGH = 3'h3;
	localparam logic [2:0] MUX_RDIV = 3'h4;
	localparam logic [2:0] MUX_RAPID = 3'h6;
	localparam logic [2:0] MUX_LOW = 3'h7;
	localparam int LOCK_CNT_NARROW = 24;
	localparam int LOCK_CNT_WIDE = 40;
	localparam int SET_ERR_NS = 15;
	localparam int CLEAR_ERR_NS = 30;
	localparam int CLK_PERIOD_NS = 40;
	localparam int SET_ERR_CYC = (SET_ERR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLEAR_ERR_CYC = CLEAR_ERR_NS / CLK_PERIOD_NS > 0
		? CLEAR_ERR_NS / CLK_PERIOD_NS : 1;
endpackage : fdp_pkg

// ---- sim/fdp_chk.sv ----
`timescale 1ns/100ps
// ==========================================
// Checker on the divider register ports.
module fdp_chk
	import fdp_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic latch_en,
	input wire logic lock_window_select,
	input wire logic ref_phase,
	input wire logic fb_phase,
	input wire logic lock_detect,
	input wire logic prescaler_select,
	input wire logic test_out_oe,
	input wire logic [3:0] cp_setting,
	input wire logic [3:0] cp_current,
	input wire logic [11:0] resync_delay
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic [3:0] age;
	logic [6:0] cyc;
	logic loaded;
	// Reference edges are counted two clocks late, as the pin synchroniser
	// delivers them to the lock counter.
	logic [2:0] ref_d;
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			age <= 4'hF;
			cyc <= 7'h00;
			loaded <= 1'b0;
			ref_d <= 3'h0;
		end
		else
		begin
			age <= latch_en ? 4'h0 : age + {3'h0, age != 4'hF};
			cyc <= lock_detect ? 7'h00
				: cyc + {6'h00, ref_d[1] && !ref_d[2] && cyc != 7'h7F};
			loaded <= loaded | latch_en;
			ref_d <= {ref_d[1:0], ref_phase};
		end
	end
	sequence s_big_err;
		lock_detect && $rose(ref_phase) && !fb_phase ##1 !fb_phase [*4];
	endsequence
	property p_cp_follow;
		$past(nrst) && cp_current != CP_MAX |-> cp_current == $past(cp_setting);
	endproperty
	property p_resync_load;
		$changed(resync_delay) |-> age < 4'h8;
	endproperty
	property p_presc_load;
		$changed(prescaler_select) |-> age < 4'h8;
	endproperty
	property p_oe_load;
		$changed(test_out_oe) |-> age < 4'h8;
	endproperty
	property p_tri_reset;
		!loaded |-> !test_out_oe;
	endproperty
	property p_lock_narrow;
		$rose(lock_detect) && !lock_window_select |-> cyc >= 7'h18;
	endproperty
	property p_lock_wide;
		$rose(lock_detect) && lock_window_select |-> cyc >= 7'h28;
	endproperty
	property p_lock_err;
		s_big_err |-> ##[1:16] !lock_detect;
	endproperty
	a_cp_follow: assert property (p_cp_follow)
		else $error("charge pump current wrong");
	a_resync_load: assert property (p_resync_load)
		else $error("resync delay moved without load");
	a_presc_load: assert property (p_presc_load)
		else $error("prescaler moved without load");
	a_oe_load: assert property (p_oe_load)
		else $error("output enable moved without load");
	a_tri_reset: assert property (p_tri_reset)
		else $error("output driven before any load");
	a_lock_narrow: assert property (p_lock_narrow)
		else $error("lock too early");
	a_lock_wide: assert property (p_lock_wide)
		else $error("wide lock too early");
	a_lock_err: assert property (p_lock_err)
		else $error("lock kept after large error");
endmodule : fdp_chk
bind fdp_divider_regs fdp_chk chk_u (.*);

// ---- sim/fdp_host.sv ----
`timescale 1ns/100ps
// ==========================================
// Serial host that programs the divider words.
module fdp_host
(
	input wire logic clk,
	output logic ser_clk,
	output logic ser_data,
	output logic latch_en
);
	initial
	begin
		ser_clk = 1'b0;
		ser_data = 1'b0;
		latch_en = 1'b0;
	end
	// Holds each level three clocks so the synchronisers see it.
	task automatic hold();
		repeat (3) @(posedge clk);
		#2;
	endtask : hold
	// Shifts a word out and pulses the latch.
	task automatic send(input logic [23:0] w);
		for (int i = 23; i >= 0; i--)
		begin
			ser_data = w[i];
			hold();
			ser_clk = 1'b1;
			hold();
			ser_clk = 1'b0;
		end
		ser_data = ~w[0];
		latch_en = 1'b1;
		hold();
		latch_en = 1'b0;
		hold();
	endtask : send
endmodule : fdp_host

// ---- sim/tb.sv ----
`timescale 1ns/100ps
// ==========================================
// Testbench for the divider registers.
module tb;
	import fdp_pkg::*;
	logic clk = 1'b0, nrst = 1'b0, lock_window_select = 1'b0;
	logic reference_input = 1'b0, rf_input = 1'b0;
	logic ref_phase = 1'b0, fb_phase = 1'b0, ser_clk, ser_data, latch_en;
	logic test_out_o, test_out_oe, lock_detect, prescaler_select;
	logic phase_comparator_ref, phase_comparator_fb;
	logic [3:0] cp_setting = 4'h5, cp_current, pc = 4'h0, fb_delay = 4'h0;
	logic [11:0] resync_delay;
	int mismatches = 0, cmp_count = 0;
	fdp_host host_u (.clk(clk), .ser_clk(ser_clk), .ser_data(ser_data),
		.latch_en(latch_en));
	fdp_divider_regs dut_u (.clk(clk), .nrst(nrst), .ser_clk(ser_clk),
		.ser_data(ser_data), .latch_en(latch_en), .rf_input(rf_input),
		.reference_input(reference_input), .cp_setting(cp_setting),
		.lock_window_select(lock_window_select), .ref_phase(ref_phase),
		.fb_phase(fb_phase), .cp_current(cp_current), .test_out_o(test_out_o),
		.test_out_oe(test_out_oe), .lock_detect(lock_detect),
		.phase_comparator_ref(phase_comparator_ref),
		.phase_comparator_fb(phase_comparator_fb),
		.prescaler_select(prescaler_select), .resync_delay(resync_delay));
	always #20 clk = ~clk;
	always @(posedge clk)
	begin
		#2;
		pc = pc + 4'h1;
		reference_input = pc[2];
		rf_input = pc[2] ^ pc[3];
		ref_phase = pc < 4'h8;
		fb_phase = (pc - fb_delay) < 4'h8;
	end
	task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wait_lock(input logic v);
		for (int i = 0; i < 1500 && lock_detect !== v; i++)
		begin
			@(posedge clk);
			#2;
		end
		cmp({11'h000, lock_detect}, {11'h000, v});
	endtask : wait_lock
	// Counts clocks across n toggles of a divided clock after its first toggle.
	task automatic span(input logic fb, input int n, input logic [11:0] exp);
		int c;
		int t;
		logic last;
		c = 0;
		t = -1;
		last = fb ? phase_comparator_fb : phase_comparator_ref;
		while (t < n && c < 4000)
		begin
			@(posedge clk);
			#2;
			c++;
			if ((fb ? phase_comparator_fb : phase_comparator_ref) !== last)
			begin
				last = ~last;
				t++;
				c = (t == 0) ? 0 : c;
			end
		end
		cmp(12'(c), exp);
	endtask : span
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : close_out
	initial
	begin
		#1600000;
		mismatches++;
		close_out();
	end
	initial
	begin
		repeat (10) @(posedge clk);
		#2;
		nrst = 1'b1;
		cmp({lock_detect, prescaler_select, test_out_oe, cp_current}, 12'h000);
		host_u.send({1'b1, MUX_RAPID, 2'b01, 4'h3, 12'hABC, SEL_R_WORD});
		cmp(resync_delay, 12'hABC);
		cmp({11'h000, prescaler_select}, 12'h001);
		host_u.send({1'b1, 9'h05B, 12'h001, SEL_N_WORD});
		cmp({8'h00, cp_current}, {8'h00, CP_MAX});
		cmp({10'h000, test_out_oe, test_out_o}, 12'h002);
		host_u.send({1'b0, 9'h05B, 12'h001, SEL_N_WORD});
		cmp({8'h00, cp_current}, 12'h005);
		cmp({11'h000, test_out_oe}, 12'h000);
		cp_setting = 4'hA;
		repeat (2) @(posedge clk);
		#2;
		cmp({8'h00, cp_current}, 12'h00A);
		for (int c = 2; c < 4; c++)
		begin
			host_u.send({1'b1, MUX_RAPID, 2'b01, 4'h3, 12'h123, 2'(c)});
			cmp(resync_delay, 12'hABC);
		end
		host_u.send({1'b0, MUX_LOCK, 2'b00, 4'h3, 12'h010, SEL_R_WORD});
		cmp(resync_delay, 12'hABC);
		cmp({11'h000, prescaler_select}, 12'h000);
		host_u.send({1'b0, 9'h01F, 12'h004, SEL_N_WORD});
		// Four toggles of 31 and 4/16 input rises each, 16 clocks per rise.
		span(1'b1, 4, 12'h7D0);
		// Two toggles of the reference divided by 3, 8 clocks per period.
		span(1'b0, 2, 12'h030);
		wait_lock(1'b1);
		@(posedge clk);
		#2;
		cmp({10'h000, test_out_oe, test_out_o}, 12'h003);
		fb_delay = 4'h6;
		wait_lock(1'b0);
		fb_delay = 4'h0;
		wait_lock(1'b1);
		host_u.send({1'b0, 9'h020, 12'h004, SEL_N_WORD});
		cmp({11'h000, lock_detect}, 12'h000);
		lock_window_select = 1'b1;
		repeat (480) @(posedge clk);
		#2;
		cmp({11'h000, lock_detect}, 12'h000);
		wait_lock(1'b1);
		host_u.send({1'b1, MUX_HIGH, 2'b00, 4'h3, 12'hABC,
			SEL_R_WORD});
		cmp({10'h000, test_out_oe, test_out_o}, 12'h003);
		host_u.send({1'b1, MUX_LOW, 2'b00, 4'h3, 12'hABC,
			SEL_R_WORD});
		cmp({10'h000, test_out_oe, test_out_o}, 12'h002);
		host_u.send({1'b1, MUX_TRISTATE, 2'b00, 4'h3, 12'hABC,
			SEL_R_WORD});
		cmp({10'h000, test_out_oe, test_out_o}, 12'h000);
		close_out();
	end
endmodule : tb
